// [logic/pof_pkg.sv]
`default_nettype none
// ****************************************************************
// Shared constants and carriers of the parallel output formatter
// ****************************************************************
package pof_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int           DATA_W            = 25;     // Parallel output width
    localparam int           ADDR_W            = 8;      // Register address width
    localparam int           REG_W             = 32;     // Register data width
    localparam int           PIN25_POS         = 24;     // Index of output pin 25
    localparam int           PIN24_POS         = 23;     // Index of output pin 24

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0]   ADDR_MODE         = 8'h00;  // Format and source selector
    localparam logic [7:0]   ADDR_POLARITY     = 8'h01;  // Output polarity selector
    localparam logic [7:0]   ADDR_UPDATE       = 8'h02;  // Refresh interval, milliseconds
    localparam logic [7:0]   ADDR_PIN_ROLE     = 8'h03;  // Top pin role selector
    localparam logic [7:0]   ADDR_OUT_WORD     = 8'h04;  // Read-only output word
    localparam logic [7:0]   ADDR_IRQ_STATUS   = 8'h05;  // Sticky events, write one clears
    localparam logic [7:0]   ADDR_IRQ_MASK     = 8'h06;  // Event enables
    localparam logic [7:0]   ADDR_TEST_WORD    = 8'hB1;  // Serial test word, test_word_access_code

    // ************************************************************
    // Mode selector codes
    // ************************************************************
    localparam logic [2:0]   MODE_MEAS_BIN     = 3'h0;   // Measurement, binary
    localparam logic [2:0]   MODE_MEAS_GRAY    = 3'h1;   // Measurement, Gray
    localparam logic [2:0]   MODE_MEAS_BCD     = 3'h2;   // Measurement, BCD
    localparam logic [2:0]   MODE_TEST_BIN     = 3'h3;   // Test word, binary
    localparam logic [2:0]   MODE_TEST_GRAY    = 3'h4;   // Test word, Gray
    localparam logic [2:0]   MODE_TEST_BCD     = 3'h5;   // Test word, BCD

    // ************************************************************
    // Reset values and limits
    // ************************************************************
    localparam logic [2:0]   MODE_RST          = 3'h0;   // Binary from measurement
    localparam logic         POLARITY_RST      = 1'b0;   // Normal polarity
    localparam logic [13:0]  UPDATE_RST        = 14'h000A; // 0.010 s
    localparam logic [13:0]  UPDATE_MIN        = 14'h0001; // 0.001 s
    localparam logic [13:0]  UPDATE_MAX        = 14'h270F; // 9.999 s
    localparam logic [3:0]   PIN_ROLE_RST      = 4'h0;   // Data and data
    localparam logic [3:0]   PIN_ROLE_MAX      = 4'hA;   // Highest role code
    localparam logic [24:0]  TEST_WORD_RST     = 25'h0000000; // Zero

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int           CLK_HZ            = 40000000; // System clock rate
    localparam real          UPDATE_UNIT_S     = 0.001;    // Interval unit, seconds
    localparam int           MS_CYCLES         = int'(CLK_HZ * UPDATE_UNIT_S); // Cycles per unit

    // ************************************************************
    // Interrupt bits
    // ************************************************************
    localparam int           IRQ_W             = 2;      // Number of events
    localparam int           IRQ_REFRESH       = 0;      // Output refreshed
    localparam int           IRQ_ERROR         = 1;      // Error flag rose
    localparam logic [1:0]   IRQ_RST           = 2'h0;   // Cleared at reset

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [DATA_W-1:0] word;                        // Scaled measurement, signed
        logic              error;                       // Core error flag
        logic              stable;                      // Core data-stable flag
    } pof_meas_s;

    typedef struct packed {
        logic [2:0]  mode;                              // Format and source
        logic        invert;                            // Output polarity
        logic [13:0] interval;                          // Refresh interval, ms
        logic [3:0]  pin_role;                          // Top pin role
    } pof_cfg_s;

endpackage : pof_pkg
`default_nettype wire

// [logic/pof_formatter.sv]
// Operation
// - Normal modes output the scaled measurement word
// - Selector 0,1,2 gives binary, Gray, BCD
// - Selector 3,4,5 encodes the test word
// - Polarity selector 1 inverts every output bit
// - Test word at access code, signed, resets 0
// - Refresh each interval, 0.001 to 9.999 s
// - Role 0 keeps data on pins 25, 24
// - Roles 1 to 3 place error flags
// - Roles 4, 5 place data-stable on pin 25
// - Roles 6 to 9 combine stable and error, role 10 puts stable and its inverse
`timescale 1ns/1ps
`default_nettype none
module pof_formatter #(
    parameter int MS_CYCLES = pof_pkg::MS_CYCLES         // Clock cycles per interval unit
) (
    input  wire logic                         clk_sys,
    input  wire logic                         srst,
    input  wire logic [pof_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [pof_pkg::REG_W-1:0]    reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [pof_pkg::REG_W-1:0]    reg_rdata,
    input  wire pof_pkg::pof_meas_s           meas,
    output logic      [pof_pkg::DATA_W-1:0]   par_out,
    output logic                              irq
);

    // ************************************************************
    // Encoding helpers
    // ************************************************************

    // Binary to reflected Gray
    function automatic logic [pof_pkg::DATA_W-1:0] to_gray(input logic [pof_pkg::DATA_W-1:0] v);
        to_gray = v ^ (v >> 1);
    endfunction : to_gray

    // Shift-add-three conversion; eight digits cover the full magnitude
    function automatic logic [31:0] to_bcd(input logic [pof_pkg::DATA_W-1:0] v);
        logic [31:0] d;
        d = 32'h00000000;
        for (int i = pof_pkg::DATA_W - 1; i >= 0; i--) begin
            for (int j = 0; j < 8; j++) begin
                if (d[4*j +: 4] >= 4'h5) begin
                    d[4*j +: 4] = d[4*j +: 4] + 4'h3;
                end
            end
            d = {d[30:0], v[i]};
        end
        to_bcd = d;
    endfunction : to_bcd

    // ************************************************************
    // Configuration registers
    // ************************************************************
    pof_pkg::pof_cfg_s              cfg_reg;             // Live configuration
    logic [pof_pkg::DATA_W-1:0]     test_word_reg;       // Serial test word
    logic [pof_pkg::IRQ_W-1:0]      irq_status_reg;      // Sticky events
    logic [pof_pkg::IRQ_W-1:0]      irq_mask_reg;        // Event enables
    logic [pof_pkg::DATA_W-1:0]     out_word_reg;        // Driven pin levels
    logic                           err_seen_reg;        // Error flag, last cycle
    logic [13:0]                    wr_interval;         // Requested interval
    logic                           test_in_range;       // Write fits signed range

    assign wr_interval   = reg_wdata[13:0];
    // Upper bits must all copy the sign for a legal test value
    assign test_in_range = (reg_wdata[31:24] == {8{reg_wdata[24]}});

    // Software writes; out-of-range mode, interval and role values keep the old setting
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_reg.mode     <= pof_pkg::MODE_RST;
            cfg_reg.invert   <= pof_pkg::POLARITY_RST;
            cfg_reg.interval <= pof_pkg::UPDATE_RST;
            cfg_reg.pin_role <= pof_pkg::PIN_ROLE_RST;
            irq_mask_reg     <= pof_pkg::IRQ_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                pof_pkg::ADDR_MODE: begin
                    // Codes above the test modes are not accepted
                    if (reg_wdata[31:0] <= 32'(pof_pkg::MODE_TEST_BCD)) begin
                        cfg_reg.mode <= reg_wdata[2:0];
                    end
                end
                pof_pkg::ADDR_POLARITY: begin
                    cfg_reg.invert <= reg_wdata[0];
                end
                pof_pkg::ADDR_UPDATE: begin
                    // Interval bounded to the documented span
                    if (reg_wdata[31:14] == 18'h00000 &&
                        wr_interval >= pof_pkg::UPDATE_MIN &&
                        wr_interval <= pof_pkg::UPDATE_MAX) begin
                        cfg_reg.interval <= wr_interval;
                    end
                end
                pof_pkg::ADDR_PIN_ROLE: begin
                    if (reg_wdata[31:0] <= 32'(pof_pkg::PIN_ROLE_MAX)) begin
                        cfg_reg.pin_role <= reg_wdata[3:0];
                    end
                end
                pof_pkg::ADDR_IRQ_MASK: begin
                    irq_mask_reg <= reg_wdata[pof_pkg::IRQ_W-1:0];
                end
                default: begin
                    // Other offsets hold nothing writable here
                end
            endcase
        end
    end

    // Test word lives at its serial access code
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            test_word_reg <= pof_pkg::TEST_WORD_RST;
        end else if (reg_wr && reg_addr == pof_pkg::ADDR_TEST_WORD && test_in_range) begin
            test_word_reg <= reg_wdata[pof_pkg::DATA_W-1:0];
        end
    end

    // ************************************************************
    // Refresh timing
    // ************************************************************
    logic [31:0]                    unit_cnt_reg;        // Cycles within one unit
    logic [13:0]                    ivl_cnt_reg;         // Units within one interval
    logic                           unit_tick;           // Last cycle of a unit
    logic                           refresh;             // Output update instant

    assign unit_tick = (unit_cnt_reg == 32'(MS_CYCLES - 1));
    // A shortened interval takes effect at once: compare with >=
    assign refresh   = unit_tick && (ivl_cnt_reg >= cfg_reg.interval - 14'h0001);

    // Unit prescaler, free running
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            unit_cnt_reg <= 32'h00000000;
        end else if (unit_tick) begin
            unit_cnt_reg <= 32'h00000000;
        end else begin
            unit_cnt_reg <= unit_cnt_reg + 32'h00000001;
        end
    end

    // Interval counter, restarts at each refresh
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ivl_cnt_reg <= 14'h0000;
        end else if (refresh) begin
            ivl_cnt_reg <= 14'h0000;
        end else if (unit_tick) begin
            ivl_cnt_reg <= ivl_cnt_reg + 14'h0001;
        end
    end

    // ************************************************************
    // Encoding path
    // ************************************************************
    logic [pof_pkg::DATA_W-1:0]     src_word;            // Selected source value
    logic [pof_pkg::DATA_W-1:0]     src_mag;             // Magnitude for BCD
    logic [31:0]                    src_bcd;             // Decimal digits
    logic [pof_pkg::DATA_W-1:0]     enc_word;            // Encoded word
    logic [pof_pkg::DATA_W-1:0]     role_word;           // After pin roles
    logic                           err_hi;              // Error, active high
    logic                           stb_hi;              // Data stable, active high

    // Source: measurement for codes 0..2, test word above
    always_comb begin
        if (cfg_reg.mode >= pof_pkg::MODE_TEST_BIN) begin
            src_word = test_word_reg;
        end else begin
            src_word = meas.word;
        end
    end

    // BCD carries the magnitude; the most negative value still fits
    assign src_mag = src_word[pof_pkg::DATA_W-1] ? (~src_word + 25'h0000001) : src_word;
    assign src_bcd = to_bcd(src_mag);

    // Format select; BCD keeps the low digits the pins can hold
    always_comb begin
        case (cfg_reg.mode)
            pof_pkg::MODE_MEAS_BIN,
            pof_pkg::MODE_TEST_BIN: begin
                enc_word = src_word;
            end
            pof_pkg::MODE_MEAS_GRAY,
            pof_pkg::MODE_TEST_GRAY: begin
                enc_word = to_gray(src_word);
            end
            pof_pkg::MODE_MEAS_BCD,
            pof_pkg::MODE_TEST_BCD: begin
                enc_word = src_bcd[pof_pkg::DATA_W-1:0];
            end
            default: begin
                enc_word = src_word;
            end
        endcase
    end

    assign err_hi = meas.error;
    assign stb_hi = meas.stable;

    // Top two pins take data, error or data-stable roles
    always_comb begin
        role_word = enc_word;
        case (cfg_reg.pin_role)
            4'h0: begin
                role_word = enc_word;
            end
            4'h1: begin
                role_word[pof_pkg::PIN25_POS] = err_hi;
            end
            4'h2: begin
                role_word[pof_pkg::PIN25_POS] = ~err_hi;
            end
            4'h3: begin
                role_word[pof_pkg::PIN25_POS] = err_hi;
                role_word[pof_pkg::PIN24_POS] = ~err_hi;
            end
            4'h4: begin
                role_word[pof_pkg::PIN25_POS] = stb_hi;
            end
            4'h5: begin
                role_word[pof_pkg::PIN25_POS] = ~stb_hi;
            end
            4'h6: begin
                role_word[pof_pkg::PIN25_POS] = stb_hi;
                role_word[pof_pkg::PIN24_POS] = err_hi;
            end
            4'h7: begin
                role_word[pof_pkg::PIN25_POS] = stb_hi;
                role_word[pof_pkg::PIN24_POS] = ~err_hi;
            end
            4'h8: begin
                role_word[pof_pkg::PIN25_POS] = ~stb_hi;
                role_word[pof_pkg::PIN24_POS] = err_hi;
            end
            4'h9: begin
                role_word[pof_pkg::PIN25_POS] = ~stb_hi;
                role_word[pof_pkg::PIN24_POS] = ~err_hi;
            end
            4'hA: begin
                role_word[pof_pkg::PIN25_POS] = stb_hi;
                role_word[pof_pkg::PIN24_POS] = ~stb_hi;
            end
            default: begin
                role_word = enc_word;
            end
        endcase
    end

    // ************************************************************
    // Output register
    // ************************************************************

    // Captured only at refresh, so pins never glitch between updates
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_word_reg <= {pof_pkg::DATA_W{1'b0}};
        end else if (refresh) begin
            out_word_reg <= role_word ^ {pof_pkg::DATA_W{cfg_reg.invert}};
        end
    end

    assign par_out = out_word_reg;

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic [pof_pkg::IRQ_W-1:0]      irq_set;             // Events this cycle
    logic [pof_pkg::IRQ_W-1:0]      irq_clr;             // Write-one clears

    assign irq_set[pof_pkg::IRQ_REFRESH] = refresh;
    assign irq_set[pof_pkg::IRQ_ERROR]   = meas.error & ~err_seen_reg;
    assign irq_clr = (reg_wr && reg_addr == pof_pkg::ADDR_IRQ_STATUS) ?
                     reg_wdata[pof_pkg::IRQ_W-1:0] : {pof_pkg::IRQ_W{1'b0}};

    // Error edge detector
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            err_seen_reg <= 1'b0;
        end else begin
            err_seen_reg <= meas.error;
        end
    end

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_status_reg <= pof_pkg::IRQ_RST;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ************************************************************
    // Read port
    // ************************************************************

    // Read data valid the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                pof_pkg::ADDR_MODE:       reg_rdata <= 32'(cfg_reg.mode);
                pof_pkg::ADDR_POLARITY:   reg_rdata <= 32'(cfg_reg.invert);
                pof_pkg::ADDR_UPDATE:     reg_rdata <= 32'(cfg_reg.interval);
                pof_pkg::ADDR_PIN_ROLE:   reg_rdata <= 32'(cfg_reg.pin_role);
                pof_pkg::ADDR_OUT_WORD:   reg_rdata <= 32'(out_word_reg);
                pof_pkg::ADDR_IRQ_STATUS: reg_rdata <= 32'(irq_status_reg);
                pof_pkg::ADDR_IRQ_MASK:   reg_rdata <= 32'(irq_mask_reg);
                // Signed test word reads back sign-extended
                pof_pkg::ADDR_TEST_WORD:  reg_rdata <= {{7{test_word_reg[pof_pkg::DATA_W-1]}}, test_word_reg};
                default:                  reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule : pof_formatter
`default_nettype wire

// [testbench/pof_formatter_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checks of the output formatter
// ****************************************
module pof_formatter_chk #(
    parameter int MS_CYCLES = 4                    // Four or more keeps the hold check valid
) (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [24:0] par_out,
    input wire logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic unmapped;                                // Address outside the map
    assign unmapped = reg_addr > pof_pkg::ADDR_IRQ_MASK && reg_addr != pof_pkg::ADDR_TEST_WORD;

    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    a_unmapped_read: assert property (reg_rd && unmapped |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_mode_range: assert property (reg_rd && reg_addr == pof_pkg::ADDR_MODE |=> reg_rdata <= 32'h5)
        else $error("mode holds a refused code");
    a_role_range: assert property (reg_rd && reg_addr == pof_pkg::ADDR_PIN_ROLE |=> reg_rdata <= 32'hA)
        else $error("pin role holds a refused code");
    a_pol_bit: assert property (reg_rd && reg_addr == pof_pkg::ADDR_POLARITY |=> reg_rdata[31:1] == 31'h0)
        else $error("polarity upper bits set");
    a_test_sign: assert property (reg_rd && reg_addr == pof_pkg::ADDR_TEST_WORD |=>
        reg_rdata[31:25] == {7{reg_rdata[24]}})
        else $error("test word not sign extended");
    // Refreshes come at least one prescale apart, so a change is followed by rest
    a_out_hold: assert property ($changed(par_out) |=> $stable(par_out)[*3])
        else $error("output moved between refreshes");
    a_reset_out: assert property ($fell(srst) |-> par_out == 25'h0 && !irq)
        else $error("outputs not cleared by reset");
    a_mask_off: assert property (reg_wr && reg_addr == pof_pkg::ADDR_IRQ_MASK && reg_wdata[1:0] == 2'h0 |=> !irq)
        else $error("interrupt with all events masked");
endmodule : pof_formatter_chk
bind pof_formatter pof_formatter_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk_sys(clk_sys), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .par_out(par_out), .irq(irq));
`default_nettype wire

// [testbench/pof_reader.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// External equipment reading the pins
// ****************************************
module pof_reader (
    input wire logic        clk_sys,
    input wire logic [24:0] par_out,
    output int              gap
);
    logic [24:0] last = 25'h0;                     // Pins seen one cycle ago
    int          run  = 0;                         // Cycles since last change
    // Time between pin changes; only meaningful while the source moves
    always_ff @(posedge clk_sys) begin
        last <= par_out;
        if (par_out !== last) begin
            gap <= run + 1;
            run <= 0;
        end else begin
            run <= run + 1;
        end
    end
endmodule : pof_reader
`default_nettype wire

// [testbench/tb_parallel_output_formatter.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench of the output formatter
// ****************************************
module tb_parallel_output_formatter;
    localparam int         MS = 4;                 // Short prescale for simulation
    localparam logic [24:0] TW = 25'h0ABCDEF;     // Test word used
    logic               clk_sys = 1'b0;
    logic               srst = 1'b1;
    logic [7:0]         reg_addr = 8'h0;
    logic [31:0]        reg_wdata = 32'h0;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [31:0]        reg_rdata;
    logic [24:0]        par_out;
    logic               irq;
    pof_pkg::pof_meas_s meas = '0;                 // Core side stimulus
    logic               spin = 1'b0;               // Step the word each cycle
    int                 bad_count = 0;
    int                 total_checks = 0;
    int                 cyc = 0;
    int                 gap;

    initial forever #12.5 clk_sys = ~clk_sys;
    pof_formatter #(.MS_CYCLES(MS)) dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas),
        .par_out(par_out), .irq(irq));
    pof_reader u_rdr (.clk_sys(clk_sys), .par_out(par_out), .gap(gap));

    // Hang guard, far above the fewer than a thousand cycles needed
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // Counting, not toggling: an even refresh spacing would see one word
    always @(posedge clk_sys) if (spin) meas.word <= meas.word + 25'h0000001;

    task automatic report_and_stop();
        if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    // With interval one, ten cycles cover at least two refreshes
    task automatic wait_out(input logic [24:0] exp);
        repeat (10) @(posedge clk_sys);
        #1 chk({7'h0, par_out}, {7'h0, exp});
    endtask : wait_out
    function automatic logic [24:0] enc(input logic [2:0] m, input logic [24:0] v);
        logic [24:0] mag;
        logic [31:0] b;
        b = 32'h0;
        mag = v[24] ? -v : v;                      // Sign dropped in decimal
        for (int i = 0; i < 8; i++) begin
            b[4*i+:4] = 4'(mag % 10);
            mag = mag / 10;
        end
        case (m % 3)
            0: return v;
            1: return v ^ (v >> 1);
            default: return b[24:0];
        endcase
    endfunction : enc
    function automatic logic [24:0] pins(input logic [24:0] w, input logic [3:0] r, input logic e, input logic s);
        logic [24:0] o;
        o = w;
        case (r)
            1: o[24] = e;
            2: o[24] = !e;
            3: o[24:23] = {e, !e};
            4: o[24] = s;
            5: o[24] = !s;
            6: o[24:23] = {s, e};
            7: o[24:23] = {s, !e};
            8: o[24:23] = {!s, e};
            9: o[24:23] = {!s, !e};
            10: o[24:23] = {s, !s};
            default: ;
        endcase
        return o;
    endfunction : pins

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        rd(pof_pkg::ADDR_IRQ_STATUS, 32'h0);
        rd(pof_pkg::ADDR_MODE, 32'h0);
        rd(pof_pkg::ADDR_POLARITY, 32'h0);
        rd(pof_pkg::ADDR_UPDATE, 32'hA);
        rd(pof_pkg::ADDR_PIN_ROLE, 32'h0);
        rd(pof_pkg::ADDR_TEST_WORD, 32'h0);
        rd(8'h07, 32'h0);
        wr(pof_pkg::ADDR_UPDATE, 32'h1);
        wr(pof_pkg::ADDR_UPDATE, 32'h0);
        rd(pof_pkg::ADDR_UPDATE, 32'h1);
        wr(pof_pkg::ADDR_TEST_WORD, 32'hFF000000);
        rd(pof_pkg::ADDR_TEST_WORD, 32'hFF000000);
        wr(pof_pkg::ADDR_TEST_WORD, {7'h0, TW});
        wr(pof_pkg::ADDR_TEST_WORD, 32'h01000000);
        rd(pof_pkg::ADDR_TEST_WORD, {7'h0, TW});
        @(posedge clk_sys);
        meas.word <= 25'h1ED2979;                  // Negative measurement
        for (int m = 0; m < 6; m++) begin
            wr(pof_pkg::ADDR_MODE, 32'(m));
            wait_out(enc(3'(m), m < 3 ? meas.word : TW));
        end
        wr(pof_pkg::ADDR_MODE, 32'h6);
        rd(pof_pkg::ADDR_MODE, 32'h5);
        wr(pof_pkg::ADDR_MODE, 32'h0);
        wr(pof_pkg::ADDR_POLARITY, 32'h1);
        wait_out(~meas.word);
        wr(pof_pkg::ADDR_POLARITY, 32'h0);
        meas.word <= 25'h0812345;                  // Bit 24 low, bit 23 high
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            // Flags opposite per pass, so each polarity differs from data
            meas.error <= (k == 0);
            meas.stable <= (k == 1);
            for (int r = 0; r < 11; r++) begin
                wr(pof_pkg::ADDR_PIN_ROLE, 32'(r));
                wait_out(pins(25'h0812345, 4'(r), k == 0, k == 1));
            end
        end
        wr(pof_pkg::ADDR_POLARITY, 32'h1);
        wait_out(~pins(25'h0812345, 4'hA, 1'b0, 1'b1));
        rd(pof_pkg::ADDR_OUT_WORD, {7'h0, ~pins(25'h0812345, 4'hA, 1'b0, 1'b1)});
        wr(pof_pkg::ADDR_PIN_ROLE, 32'hB);
        rd(pof_pkg::ADDR_PIN_ROLE, 32'hA);
        wr(pof_pkg::ADDR_PIN_ROLE, 32'h0);
        wr(pof_pkg::ADDR_POLARITY, 32'h0);
        wr(pof_pkg::ADDR_UPDATE, 32'h3);
        spin <= 1'b1;
        repeat (40) @(posedge clk_sys);
        chk(32'(gap), 32'(3 * MS));
        spin <= 1'b0;
        // Interrupts: mask, raise, clear
        wr(pof_pkg::ADDR_UPDATE, 32'd100);
        wr(pof_pkg::ADDR_IRQ_MASK, 32'h0);
        rd(pof_pkg::ADDR_IRQ_STATUS, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr(pof_pkg::ADDR_IRQ_MASK, 32'h1);
        wr(pof_pkg::ADDR_IRQ_STATUS, 32'h3);
        #1;                                        // Let the clear land before polling
        for (int i = 0; i < 500 && !irq; i++) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        wr(pof_pkg::ADDR_IRQ_STATUS, 32'h1);
        #1 chk({31'h0, irq}, 32'h0);
        @(posedge clk_sys);
        meas.error <= 1'b1;                        // Error event
        wr(pof_pkg::ADDR_IRQ_MASK, 32'h2);
        #1 chk({31'h0, irq}, 32'h1);
        rd(pof_pkg::ADDR_IRQ_STATUS, 32'h2);
        report_and_stop();
    end
endmodule : tb_parallel_output_formatter
`default_nettype wire
